// *** include/ccd_pkg.sv ***
// Shared constants and types for the call, clear and decrement execution core.
`default_nettype none
package ccd_pkg;
  localparam int PC_W   = 13;
  localparam int TGT_W  = 11;
  localparam int DATA_W = 8;
  localparam int REG_AW = 7;

  // Operation selector presented with each instruction.
  typedef enum logic [2:0] {
    CCD_OP_KICK,
    CCD_OP_CALL,
    CCD_OP_INVERT,
    CCD_OP_REG_ZERO,
    CCD_OP_DEC,
    CCD_OP_ACC_ZERO
  } ccd_op_t;

  // Result destination select values.
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_REG = 1'b1;

  // Page latch bits that feed the top of the program counter.
  localparam int PAGE_LO = 3;
  localparam int PAGE_HI = 4;

  // Register byte addresses on the bus.
  localparam logic [31:0] ADDR_PAGE   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_PC     = 32'h0000_0008;
  localparam logic [31:0] ADDR_ACC    = 32'h0000_000C;
  localparam logic [31:0] ADDR_STACK  = 32'h0000_0010;

  // Status register bit positions.
  localparam int ST_ZERO  = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_EXPIRY = 2;

  // Values after reset.
  localparam logic [PC_W-1:0]   RST_PC     = 13'h0000;
  localparam logic [DATA_W-1:0] RST_ACC    = 8'h00;
  localparam logic [DATA_W-1:0] RST_PAGE   = 8'h00;
  localparam logic              RST_ZERO   = 1'b0;
  localparam logic              RST_SLEEP  = 1'b1;
  localparam logic              RST_EXPIRY = 1'b1;
  localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
endpackage : ccd_pkg
`default_nettype wire

// *** include/ccd_mem_if.sv ***
// Interface between the execution core and its general register file.
`default_nettype none
interface ccd_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;

  modport core (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : ccd_mem_if
`default_nettype wire

// *** hdl/ccd_regfile.sv ***
// General register file with registered read data.
`default_nettype none
module ccd_regfile #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst,
  ccd_mem_if.mem   port
);
  localparam int DEPTH = 1 << AW;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] cells;
    logic [DW-1:0]            rd_data;
  } ccd_rf_state_t;

  ccd_rf_state_t s;
  ccd_rf_state_t next_s;

  // A read of the cell being written returns the old value; the core forwards around it.
  always_comb begin
    next_s = s;
    next_s.rd_data = s.cells[port.rd_addr];
    if (port.wr_en) begin
      next_s.cells[port.wr_addr] = port.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.rd_data = s.rd_data;
endmodule : ccd_regfile
`default_nettype wire

// *** hdl/ccd_core.sv ***
// Execution core for watchdog kick, call, invert, clear and decrement instructions.
// Contract
// [RULE1] Watchdog kick zeroes the watchdog counter.
// [RULE2] Watchdog kick also zeroes its prescaler.
// [RULE3] Watchdog kick sets expiry and sleep flags.
// [RULE4] Call pushes program counter plus one.
// [RULE5] Call loads target into counter bits 10:0.
// [RULE6] Call loads counter bits 12:11 from latch.
// [RULE7] Call takes two cycles, flags untouched.
// [RULE8] Select 0 writes accumulator, 1 writes register.
// [RULE9] Invert writes complement, updates zero flag only.
// [RULE10] Register clear writes zero, sets zero flag.
// [RULE11] Decrement writes value minus one, zero flag.
// [RULE12] Accumulator clear zeroes it, sets zero flag.
// [RULE13] Other instructions take one cycle, no discard.
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`default_nettype none
module ccd_core (
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            hsel,
  input  wire logic [31:0]                     haddr,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     hwdata,
  input  wire logic                            hready,
  output logic                                 hreadyout,
  output logic [31:0]                          hrdata,
  output logic                                 hresp,
  input  wire logic                            instr_valid,
  input  wire ccd_pkg::ccd_op_t                instr_op,
  input  wire logic [ccd_pkg::REG_AW-1:0]      instr_reg,
  input  wire logic                            instr_dest,
  input  wire logic [ccd_pkg::TGT_W-1:0]       instr_target,
  output logic                                 instr_ready,
  output logic [ccd_pkg::PC_W-1:0]             pc,
  output logic [ccd_pkg::PC_W-1:0]             stack_top,
  output logic                                 stack_push,
  output logic                                 wdt_clear,
  output logic                                 prescaler_clear,
  output logic [ccd_pkg::DATA_W-1:0]           accumulator,
  output logic                                 result_null_flag,
  output logic                                 watchdog_expiry_flag,
  output logic                                 sleep_entered_flag
);
  typedef struct packed {
    logic [ccd_pkg::PC_W-1:0]   pc;
    logic [ccd_pkg::PC_W-1:0]   stack_top;
    logic                       stack_push;
    logic                       wdt_clear;
    logic                       prescaler_clear;
    logic [ccd_pkg::DATA_W-1:0] acc;
    logic                       zero;
    logic                       expiry;
    logic                       sleep;
    logic [ccd_pkg::DATA_W-1:0] page;
    logic                       ready;
    logic                       call_wait;
    logic                       e_valid;
    ccd_pkg::ccd_op_t           e_op;
    logic [ccd_pkg::REG_AW-1:0] e_reg;
    logic                       e_dest;
    logic                       fwd;
    logic [ccd_pkg::DATA_W-1:0] fwd_val;
    logic                       a_valid;
    logic                       a_write;
    logic [31:0]                a_addr;
    logic [31:0]                hrdata;
    logic                       hreadyout;
  } ccd_state_t;

  ccd_state_t s;
  ccd_state_t next_s;

  ccd_mem_if #(.AW(ccd_pkg::REG_AW), .DW(ccd_pkg::DATA_W)) mem_bus ();

  ccd_regfile #(
    .AW (ccd_pkg::REG_AW),
    .DW (ccd_pkg::DATA_W)
  ) u_regfile (
    .clk  (clk),
    .rst  (rst),
    .port (mem_bus)
  );

  logic                       take;
  logic                       call_take;
  logic                       addr_phase;
  logic [ccd_pkg::DATA_W-1:0] src_e;
  logic [ccd_pkg::DATA_W-1:0] result_e;
  logic                       reg_wr_e;
  logic                       acc_wr_e;
  logic [31:0]                rd_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Datapath of the execute stage.

  assign take       = instr_valid && s.ready;
  assign call_take  = take && (instr_op == ccd_pkg::CCD_OP_CALL);
  assign addr_phase = hsel && htrans[1] && hready;

  // The register file answers one cycle after the address, so the operand is read
  // while the instruction is taken and used in the following execute cycle.
  always_comb begin
    src_e    = s.fwd ? s.fwd_val : mem_bus.rd_data;
    result_e = ccd_pkg::ZERO_BYTE;
    case (s.e_op)
      ccd_pkg::CCD_OP_INVERT: begin
        result_e = ~src_e; // [RULE9]
      end
      ccd_pkg::CCD_OP_DEC: begin
        result_e = src_e - 8'h01; // [RULE11]
      end
      default: begin
        result_e = ccd_pkg::ZERO_BYTE; // [RULE10]
      end
    endcase
    reg_wr_e = s.e_valid && ((s.e_op == ccd_pkg::CCD_OP_REG_ZERO)
               || (((s.e_op == ccd_pkg::CCD_OP_INVERT) || (s.e_op == ccd_pkg::CCD_OP_DEC))
                   && (s.e_dest == ccd_pkg::DEST_REG))); // [RULE8]
    acc_wr_e = s.e_valid && ((s.e_op == ccd_pkg::CCD_OP_INVERT) || (s.e_op == ccd_pkg::CCD_OP_DEC))
               && (s.e_dest == ccd_pkg::DEST_ACC); // [RULE8]
  end

  assign mem_bus.rd_addr = instr_reg;
  assign mem_bus.wr_en   = reg_wr_e;
  assign mem_bus.wr_addr = s.e_reg;
  assign mem_bus.wr_data = result_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus read multiplexer, sampled in the address phase.

  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr == ccd_pkg::ADDR_PAGE) begin
      rd_word = 32'(s.page);
    end else if (haddr == ccd_pkg::ADDR_STATUS) begin
      rd_word[ccd_pkg::ST_ZERO]   = s.zero;
      rd_word[ccd_pkg::ST_SLEEP]  = s.sleep;
      rd_word[ccd_pkg::ST_EXPIRY] = s.expiry;
    end else if (haddr == ccd_pkg::ADDR_PC) begin
      rd_word = 32'(s.pc);
    end else if (haddr == ccd_pkg::ADDR_ACC) begin
      rd_word = 32'(s.acc);
    end else if (haddr == ccd_pkg::ADDR_STACK) begin
      rd_word = 32'(s.stack_top);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_s = s;
    next_s.stack_push      = 1'b0;
    next_s.wdt_clear       = 1'b0;
    next_s.prescaler_clear = 1'b0;
    next_s.hreadyout       = 1'b1;
    next_s.a_valid         = addr_phase;
    next_s.a_write         = hwrite;
    next_s.a_addr          = haddr;
    if (addr_phase && !hwrite) begin
      next_s.hrdata = rd_word;
    end
    // Software writes go first so that a flag event from an instruction in the
    // same cycle overrides them.
    if (s.a_valid && s.a_write) begin
      if (s.a_addr == ccd_pkg::ADDR_PAGE) begin
        next_s.page = hwdata[ccd_pkg::DATA_W-1:0];
      end else if (s.a_addr == ccd_pkg::ADDR_STATUS) begin
        next_s.zero   = hwdata[ccd_pkg::ST_ZERO];
        next_s.sleep  = hwdata[ccd_pkg::ST_SLEEP];
        next_s.expiry = hwdata[ccd_pkg::ST_EXPIRY];
      end
    end
    if (s.e_valid) begin
      case (s.e_op)
        ccd_pkg::CCD_OP_KICK: begin
          next_s.wdt_clear       = 1'b1; // [RULE1]
          next_s.prescaler_clear = 1'b1; // [RULE2]
          next_s.expiry          = 1'b1; // [RULE3]
          next_s.sleep           = 1'b1; // [RULE3]
        end
        ccd_pkg::CCD_OP_INVERT, ccd_pkg::CCD_OP_DEC: begin
          if (acc_wr_e) begin
            next_s.acc = result_e; // [RULE8]
          end
          next_s.zero = (result_e == ccd_pkg::ZERO_BYTE); // [RULE9] [RULE11]
        end
        ccd_pkg::CCD_OP_REG_ZERO: begin
          next_s.zero = 1'b1; // [RULE10]
        end
        ccd_pkg::CCD_OP_ACC_ZERO: begin
          next_s.acc  = ccd_pkg::ZERO_BYTE; // [RULE12]
          next_s.zero = 1'b1; // [RULE12]
        end
        default: begin
        end
      endcase
    end
    next_s.e_valid = 1'b0;
    next_s.fwd     = 1'b0;
    if (s.call_wait) begin
      // Second cycle of a call: nothing is taken.
      next_s.call_wait = 1'b0; // [RULE7]
      next_s.ready     = 1'b1; // [RULE7]
    end else if (take) begin
      next_s.pc      = s.pc + 13'h0001; // [RULE13]
      next_s.e_valid = (instr_op != ccd_pkg::CCD_OP_CALL);
      next_s.e_op    = instr_op;
      next_s.e_reg   = instr_reg;
      next_s.e_dest  = instr_dest;
      // The register file returns the old value of a cell written in this cycle.
      if (reg_wr_e && (instr_reg == s.e_reg)) begin
        next_s.fwd     = 1'b1; // [RULE13]
        next_s.fwd_val = result_e;
      end
      if (instr_op == ccd_pkg::CCD_OP_CALL) begin
        next_s.stack_top  = s.pc + 13'h0001; // [RULE4]
        next_s.stack_push = 1'b1; // [RULE4]
        next_s.pc         = {s.page[ccd_pkg::PAGE_HI:ccd_pkg::PAGE_LO], instr_target}; // [RULE5] [RULE6]
        next_s.call_wait  = 1'b1; // [RULE7]
        next_s.ready      = 1'b0; // [RULE7]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s           <= '0;
      s.pc        <= ccd_pkg::RST_PC;
      s.acc       <= ccd_pkg::RST_ACC;
      s.page      <= ccd_pkg::RST_PAGE;
      s.zero      <= ccd_pkg::RST_ZERO;
      s.sleep     <= ccd_pkg::RST_SLEEP;
      s.expiry    <= ccd_pkg::RST_EXPIRY;
      s.ready     <= 1'b1;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout            = s.hreadyout;
  assign hrdata               = s.hrdata;
  assign hresp                = 1'b0;
  assign instr_ready          = s.ready;
  assign pc                   = s.pc;
  assign stack_top            = s.stack_top;
  assign stack_push           = s.stack_push;
  assign wdt_clear            = s.wdt_clear;
  assign prescaler_clear      = s.prescaler_clear;
  assign accumulator          = s.acc;
  assign result_null_flag     = s.zero;
  assign watchdog_expiry_flag = s.expiry;
  assign sleep_entered_flag   = s.sleep;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking ccd_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic kick_take;
  assign kick_take = take && !s.call_wait && (instr_op == ccd_pkg::CCD_OP_KICK);

  property p_kick_counter;
    kick_take |=> ##1 wdt_clear ##1 !wdt_clear;
  endproperty
  a_kick_counter: assert property (p_kick_counter) else $error("watchdog clear pulse wrong"); // [RULE1]

  property p_kick_prescaler;
    s.e_valid && (s.e_op == ccd_pkg::CCD_OP_KICK) |=> prescaler_clear && wdt_clear;
  endproperty
  a_kick_prescaler: assert property (p_kick_prescaler) else $error("prescaler clear missing"); // [RULE2]

  property p_kick_flags;
    s.e_valid && (s.e_op == ccd_pkg::CCD_OP_KICK) |=> watchdog_expiry_flag && sleep_entered_flag;
  endproperty
  a_kick_flags: assert property (p_kick_flags) else $error("kick did not set flags"); // [RULE3]

  property p_call_push;
    call_take && !s.call_wait |=> stack_push && (stack_top == $past(s.pc) + 13'h0001);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call return address wrong"); // [RULE4]

  property p_call_low;
    call_take && !s.call_wait |=> pc[ccd_pkg::TGT_W-1:0] == $past(instr_target);
  endproperty
  a_call_low: assert property (p_call_low) else $error("call target wrong"); // [RULE5]

  property p_call_high;
    call_take && !s.call_wait |=> pc[12:11] == $past(s.page[ccd_pkg::PAGE_HI:ccd_pkg::PAGE_LO]);
  endproperty
  a_call_high: assert property (p_call_high) else $error("call page bits wrong"); // [RULE6]

  property p_call_two;
    call_take && !s.call_wait |=> !instr_ready && !s.e_valid ##1 instr_ready && $stable(pc);
  endproperty
  a_call_two: assert property (p_call_two) else $error("call not two cycles"); // [RULE7]

  property p_dest_acc;
    acc_wr_e |=> accumulator == $past(result_e);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination wrong"); // [RULE8]

  property p_invert_zero;
    s.e_valid && (s.e_op == ccd_pkg::CCD_OP_INVERT) |=> result_null_flag == ($past(src_e) == 8'hFF);
  endproperty
  a_invert_zero: assert property (p_invert_zero) else $error("invert zero flag wrong"); // [RULE9]

  property p_reg_zero;
    s.e_valid && (s.e_op == ccd_pkg::CCD_OP_REG_ZERO) |-> mem_bus.wr_en && (mem_bus.wr_data == 8'h00)
      ##1 result_null_flag;
  endproperty
  a_reg_zero: assert property (p_reg_zero) else $error("register clear wrong"); // [RULE10]

  property p_dec_zero;
    s.e_valid && (s.e_op == ccd_pkg::CCD_OP_DEC) |=> result_null_flag == ($past(src_e) == 8'h01);
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("decrement zero flag wrong"); // [RULE11]

  property p_acc_zero;
    s.e_valid && (s.e_op == ccd_pkg::CCD_OP_ACC_ZERO) |=> (accumulator == 8'h00) && result_null_flag;
  endproperty
  a_acc_zero: assert property (p_acc_zero) else $error("accumulator clear wrong"); // [RULE12]

  property p_single;
    take && !s.call_wait && !call_take |=> instr_ready && (pc == $past(s.pc) + 13'h0001);
  endproperty
  a_single: assert property (p_single) else $error("single cycle op stalled"); // [RULE13]

  c_call: cover property (call_take ##2 take);
  c_fwd: cover property (s.fwd && s.e_valid && (s.e_op == ccd_pkg::CCD_OP_DEC));
  c_kick: cover property (kick_take ##1 s.a_valid && s.a_write);
  c_invert_reg: cover property (reg_wr_e && (s.e_op == ccd_pkg::CCD_OP_INVERT));
endmodule : ccd_core
`default_nettype wire

// *** sim/tb_core_clear_call_decrement_ops.sv ***
// Self-checking testbench for the call, clear and decrement execution core.
`default_nettype none
module tb_core_clear_call_decrement_ops;
  timeunit 1ns;
  timeprecision 1ns;

  logic                           clk;
  logic                           rst;
  logic                           hsel;
  logic [31:0]                    haddr;
  logic [1:0]                     htrans;
  logic                           hwrite;
  logic [2:0]                     hsize;
  logic [31:0]                    hwdata;
  logic                           hreadyout;
  logic [31:0]                    hrdata;
  logic                           hresp;
  logic                           instr_valid;
  ccd_pkg::ccd_op_t               instr_op;
  logic [ccd_pkg::REG_AW-1:0]     instr_reg;
  logic                           instr_dest;
  logic [ccd_pkg::TGT_W-1:0]      instr_target;
  logic                           instr_ready;
  logic [ccd_pkg::PC_W-1:0]       pc;
  logic [ccd_pkg::PC_W-1:0]       stack_top;
  logic                           stack_push;
  logic                           wdt_clear;
  logic                           prescaler_clear;
  logic [ccd_pkg::DATA_W-1:0]     accumulator;
  logic                           result_null_flag;
  logic                           watchdog_expiry_flag;
  logic                           sleep_entered_flag;
  int                             fail_count;
  int                             cmp_count;
  int                             cycles;
  logic [ccd_pkg::PC_W-1:0]       exp_pc;
  logic [31:0]                    rd;

  ccd_core dut_u (
    .clk                  (clk),
    .rst                  (rst),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hreadyout),
    .hreadyout            (hreadyout),
    .hrdata               (hrdata),
    .hresp                (hresp),
    .instr_valid          (instr_valid),
    .instr_op             (instr_op),
    .instr_reg            (instr_reg),
    .instr_dest           (instr_dest),
    .instr_target         (instr_target),
    .instr_ready          (instr_ready),
    .pc                   (pc),
    .stack_top            (stack_top),
    .stack_push           (stack_push),
    .wdt_clear            (wdt_clear),
    .prescaler_clear      (prescaler_clear),
    .accumulator          (accumulator),
    .result_null_flag     (result_null_flag),
    .watchdog_expiry_flag (watchdog_expiry_flag),
    .sleep_entered_flag   (sleep_entered_flag)
  );

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Entered just after a rising edge; returns just after the data-phase edge.
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Holds the request until the edge at which it is taken; valid stays up.
  task issue(input ccd_pkg::ccd_op_t op, input logic [6:0] r, input logic d, input logic [10:0] t);
    instr_valid  <= 1'b1;
    instr_op     <= op;
    instr_reg    <= r;
    instr_dest   <= d;
    instr_target <= t;
    do @(posedge clk); while (instr_ready !== 1'b1);
  endtask : issue

  task run1(input ccd_pkg::ccd_op_t op, input logic [6:0] r, input logic d, input logic [7:0] ea,
            input logic ez);
    issue(op, r, d, 11'h000);
    instr_valid <= 1'b0;
    exp_pc = exp_pc + 13'h0001;
    @(negedge clk);
    chk(32'(pc), 32'(exp_pc), "pc step");
    @(negedge clk);
    chk(32'(accumulator), 32'(ea), "accumulator");
    chk(32'(result_null_flag), 32'(ez), "zero flag");
    @(posedge clk);
  endtask : run1

  ////////////////////////////////////////////////////////////////////////////
  task t_reset();
    bus(1'b0, ccd_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h0000_0006, "status reset");
    bus(1'b0, ccd_pkg::ADDR_PAGE, 32'h0); chk(rd, 32'h0, "page reset");
    bus(1'b1, 32'h0000_0014, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0014, 32'h0); chk(rd, 32'h0, "unmapped");
    bus(1'b1, ccd_pkg::ADDR_PC, 32'h0000_1234);
    bus(1'b0, ccd_pkg::ADDR_PC, 32'h0); chk(rd, 32'h0, "pc read only");
    chk(32'(hresp), 32'h0, "okay");
    $display("test reset done");
  endtask : t_reset

  task t_kick();
    bus(1'b1, ccd_pkg::ADDR_STATUS, 32'h0000_0001);
    bus(1'b0, ccd_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h0000_0001, "status write");
    issue(ccd_pkg::CCD_OP_KICK, 7'h00, 1'b0, 11'h000);
    instr_valid <= 1'b0;
    exp_pc = exp_pc + 13'h0001;
    @(negedge clk);
    chk(32'(wdt_clear), 32'h0, "kick early");
    @(negedge clk);
    chk(32'(wdt_clear), 32'h1, "counter clear");
    chk(32'(prescaler_clear), 32'h1, "prescaler clear");
    chk(32'({watchdog_expiry_flag, sleep_entered_flag, result_null_flag}), 32'h7, "kick flags");
    @(negedge clk);
    chk(32'({wdt_clear, prescaler_clear}), 32'h0, "kick pulse length");
    @(posedge clk);
    bus(1'b0, ccd_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h0000_0007, "status after kick");
    $display("test kick done");
  endtask : t_kick

  task t_regops();
    run1(ccd_pkg::CCD_OP_REG_ZERO, 7'h7F, 1'b1, 8'h00, 1'b1);
    run1(ccd_pkg::CCD_OP_DEC, 7'h7F, 1'b1, 8'h00, 1'b0);
    run1(ccd_pkg::CCD_OP_INVERT, 7'h7F, 1'b0, 8'h00, 1'b1);
    run1(ccd_pkg::CCD_OP_DEC, 7'h7F, 1'b0, 8'hFE, 1'b0);
    run1(ccd_pkg::CCD_OP_INVERT, 7'h7F, 1'b1, 8'hFE, 1'b1);
    run1(ccd_pkg::CCD_OP_DEC, 7'h7F, 1'b0, 8'hFF, 1'b0);
    run1(ccd_pkg::CCD_OP_ACC_ZERO, 7'h00, 1'b0, 8'h00, 1'b1);
    run1(ccd_pkg::CCD_OP_INVERT, 7'h00, 1'b0, 8'hFF, 1'b0);
    run1(ccd_pkg::CCD_OP_DEC, 7'h01, 1'b0, 8'hFF, 1'b0);
    bus(1'b0, ccd_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h0000_0006, "other flags kept");
    $display("test register ops done");
  endtask : t_regops

  // Dependent instructions issued on consecutive edges must see each other's results.
  task t_b2b();
    issue(ccd_pkg::CCD_OP_REG_ZERO, 7'h09, 1'b1, 11'h000);
    issue(ccd_pkg::CCD_OP_DEC, 7'h09, 1'b1, 11'h000);
    // Valid must drop here, or the decrement is taken a second time.
    instr_valid <= 1'b0;
    @(negedge clk);
    chk(32'(result_null_flag), 32'h1, "b2b clear");
    @(posedge clk);
    issue(ccd_pkg::CCD_OP_INVERT, 7'h09, 1'b0, 11'h000);
    instr_valid <= 1'b0;
    exp_pc = exp_pc + 13'h0003;
    @(negedge clk);
    chk(32'(result_null_flag), 32'h0, "b2b dec");
    chk(32'(pc), 32'(exp_pc), "b2b pc");
    @(negedge clk);
    chk(32'({result_null_flag, accumulator}), 32'h100, "b2b invert");
    @(posedge clk);
    $display("test back to back done");
  endtask : t_b2b

  task t_call();
    time t0;
    bus(1'b1, ccd_pkg::ADDR_PAGE, 32'h0000_00F7);
    issue(ccd_pkg::CCD_OP_CALL, 7'h00, 1'b0, 11'h7FF);
    t0 = $time;
    @(negedge clk);
    chk(32'(pc), 32'h0000_17FF, "call target");
    chk(32'(stack_top), 32'(exp_pc + 13'h0001), "return address");
    chk(32'({stack_push, instr_ready}), 32'h2, "call busy");
    @(posedge clk);
    issue(ccd_pkg::CCD_OP_CALL, 7'h00, 1'b0, 11'h000);
    instr_valid <= 1'b0;
    chk(32'($time - t0), 32'd100, "call length");
    @(negedge clk);
    chk(32'(pc), 32'h0000_1000, "page bits");
    chk(32'(stack_top), 32'h0000_1800, "second return");
    @(posedge clk);
    exp_pc = 13'h1000;
    // The zero flag was left set by the previous test and a call must not touch it.
    bus(1'b0, ccd_pkg::ADDR_STATUS, 32'h0); chk(rd, 32'h0000_0007, "call flags");
    bus(1'b0, ccd_pkg::ADDR_STACK, 32'h0); chk(rd, 32'h0000_1800, "stack read");
    run1(ccd_pkg::CCD_OP_ACC_ZERO, 7'h00, 1'b0, 8'h00, 1'b1);
    $display("test call done");
  endtask : t_call

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("unexpected at %0t: run timed out", $time);
      results();
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    instr_valid = 1'b0;
    instr_op = ccd_pkg::CCD_OP_KICK;
    instr_reg = 7'h00;
    instr_dest = 1'b0;
    instr_target = 11'h000;
    fail_count = 0;
    cmp_count = 0;
    cycles = 0;
    exp_pc = 13'h0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_kick();
    t_regops();
    t_b2b();
    t_call();
    results();
  end
endmodule : tb_core_clear_call_decrement_ops
`default_nettype wire
